/* rtl/csv_pkg.sv */
// Purpose: Shared constants for the controller status variable bank
// Assumes: 25 MHz system clock, byte-wide block-read port
// Notes:   Offsets are byte offsets of the variable map
package csv_pkg;

  // ************************************************************
  // Variable offsets
  // ************************************************************
  localparam logic [7:0] OFS_RESET_CAUSE = 8'h32;
  localparam logic [7:0] OFS_SUPPLY_MV   = 8'h33;
  localparam logic [7:0] OFS_UPTIME      = 8'h35;
  localparam logic [7:0] OFS_QUAD        = 8'h39;
  localparam logic [7:0] OFS_HOBBY       = 8'h3D;
  localparam logic [7:0] OFS_AN_SCL      = 8'h3F;
  localparam logic [7:0] OFS_AN_SDA      = 8'h41;
  localparam logic [7:0] OFS_AN_TX       = 8'h43;
  localparam logic [7:0] OFS_AN_RX       = 8'h45;
  localparam logic [7:0] OFS_LEVELS      = 8'h47;
  localparam logic [7:0] OFS_DRIVE       = 8'h48;
  localparam logic [7:0] OFS_USTEP       = 8'h49;
  localparam int         BANK_BYTES      = 24;
  localparam logic [7:0] UNMAPPED_BYTE   = 8'h00;

  // ************************************************************
  // Codes and reset values
  // ************************************************************
  localparam logic [7:0]  CAUSE_POWER_UP = 8'h00;
  localparam logic [7:0]  CAUSE_BROWN    = 8'h01;
  localparam logic [7:0]  CAUSE_EXT_LINE = 8'h02;
  localparam logic [7:0]  CAUSE_WDOG     = 8'h04;
  localparam logic [7:0]  CAUSE_SOFTWARE = 8'h08;
  localparam logic [7:0]  CAUSE_STK_OVF  = 8'h10;
  localparam logic [7:0]  CAUSE_STK_UNF  = 8'h20;
  localparam logic [15:0] NO_READING     = 16'hFFFF;
  localparam logic [15:0] ANALOG_MAX     = 16'hFFFE;
  localparam logic [15:0] SUPPLY_RST     = 16'h0000;
  localparam logic [31:0] COUNT32_RST    = 32'h0000_0000;
  localparam logic [7:0]  USTEP_FULL     = 8'h00;
  localparam logic [7:0]  USTEP_HALF_100 = 8'h06;
  localparam logic [7:0]  USTEP_MAX      = 8'h09;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int LVL_BIT_SCL   = 0;
  localparam int LVL_BIT_SDA   = 1;
  localparam int LVL_BIT_TX    = 2;
  localparam int LVL_BIT_RX    = 3;
  localparam int LVL_BIT_HOBBY = 4;
  localparam int LVL_PINS      = 5;
  localparam int DRV_POS_SCL   = 0;
  localparam int DRV_POS_SDA   = 2;
  localparam int DRV_POS_TX    = 4;
  localparam int DRV_POS_RX    = 6;
  localparam int AN_CHANNELS   = 4;

  typedef enum logic [1:0] {
    DRV_HIGH_Z  = 2'h0,
    DRV_PULL_UP = 2'h1,
    DRV_LOW     = 2'h2,
    DRV_HIGH    = 2'h3
  } csv_drive_t;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS     = 40;
  localparam int MS_NS             = 1000000;
  localparam int CYC_PER_MS        = MS_NS / CLK_PERIOD_NS;
  localparam int HOBBY_UNITS_US    = 12;
  localparam int US_NS             = 1000;
  localparam int HOBBY_TIMEOUT_MS  = 100;
  localparam int HOBBY_TIMEOUT_CYC = HOBBY_TIMEOUT_MS * CYC_PER_MS;
  localparam logic [10:0] HOBBY_PHASE_STEP =
    11'(CLK_PERIOD_NS * HOBBY_UNITS_US);
  localparam logic [10:0] HOBBY_PHASE_WRAP = 11'(US_NS);

endpackage

/* rtl/csv_quad_dec.sv */
// Purpose: Quadrature decoder, four counts per encoder cycle
// Assumes: Inputs already synchronised to i_clk
// Notes:   A jump of both phases at once is dropped, not guessed
`timescale 1ns/1ps
`default_nettype none
module csv_quad_dec
  import csv_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_a,
  input  wire logic        i_b,
  output logic      [31:0] o_count
);

  logic        pa_r;
  logic        pb_r;
  logic        prime_r;
  logic [31:0] count_r;
  logic        one_step;

  assign one_step = (pa_r ^ i_a) ^ (pb_r ^ i_b);
  assign o_count  = count_r;

  // ************************************************************
  // Phase tracking
  // ************************************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pa_r    <= 1'b0;
      pb_r    <= 1'b0;
      prime_r <= 1'b1;
    end else begin
      pa_r    <= i_a;
      pb_r    <= i_b;
      prime_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count_r <= COUNT32_RST;
    end else if (!prime_r && one_step) begin
      if (pa_r ^ i_b) begin
        count_r <= 32'(count_r + 32'h1);
      end else begin
        count_r <= 32'(count_r - 32'h1);
      end
    end
  end

  AST_ENC_STEP : assert property (
    @(posedge i_clk) disable iff (i_rst)
    !prime_r |=> (count_r == $past(count_r)) ||
      (count_r == 32'($past(count_r) + 32'h1)) ||
      (count_r == 32'($past(count_r) - 32'h1)))
    else $error("encoder count moved by more than one");

endmodule
`default_nettype wire

/* rtl/csv_pulse_meas.sv */
// Purpose: Hobby pulse width in twelfths of a microsecond
// Assumes: Input already synchronised to i_clk
// Notes:   Fractional phase keeps the 40 ns to 83.3 ns ratio exact
`timescale 1ns/1ps
`default_nettype none
module csv_pulse_meas
  import csv_pkg::*;
#(
  parameter int P_TIMEOUT_CYC = HOBBY_TIMEOUT_CYC
)(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_pulse,
  output logic      [15:0] o_width
);

  logic        lvl_d_r;
  logic        meas_r;
  logic        ovf_r;
  logic [15:0] units_r;
  logic [10:0] phase_r;
  logic [31:0] idle_r;
  logic [15:0] width_r;
  logic [10:0] phase_sum;
  logic        rise;
  logic        fall;

  assign rise      = i_pulse && !lvl_d_r;
  assign fall      = !i_pulse && lvl_d_r;
  assign phase_sum = 11'(phase_r + HOBBY_PHASE_STEP);
  assign o_width   = width_r;

  // ************************************************************
  // High-time accumulation
  // ************************************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lvl_d_r <= 1'b0;
      meas_r  <= 1'b0;
      ovf_r   <= 1'b0;
      units_r <= 16'h0000;
      phase_r <= 11'h000;
    end else begin
      lvl_d_r <= i_pulse;
      if (rise) begin
        meas_r  <= 1'b1;
        ovf_r   <= 1'b0;
        units_r <= 16'h0000;
        phase_r <= HOBBY_PHASE_STEP;
      end else if (i_pulse && meas_r) begin
        if (phase_sum >= HOBBY_PHASE_WRAP) begin
          phase_r <= 11'(phase_sum - HOBBY_PHASE_WRAP);
          // Stop at 0xFFFE and flag overflow; an overlong pulse reads as all-ones
          if (units_r == ANALOG_MAX) begin
            ovf_r <= 1'b1;
          end else begin
            units_r <= 16'(units_r + 16'h1);
          end
        end else begin
          phase_r <= phase_sum;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      idle_r  <= 32'h0000_0000;
      width_r <= NO_READING;
    end else if (fall && meas_r) begin
      idle_r  <= 32'h0000_0000;
      width_r <= ovf_r ? NO_READING : units_r;
    end else if (idle_r == 32'(P_TIMEOUT_CYC - 1)) begin
      width_r <= NO_READING;
    end else begin
      idle_r <= 32'(idle_r + 32'h1);
    end
  end

  AST_PULSE_TIMEOUT : assert property (
    @(posedge i_clk) disable iff (i_rst)
    (idle_r == 32'(P_TIMEOUT_CYC - 1)) && !fall |=> width_r == NO_READING)
    else $error("pulse width not invalidated after timeout");

endmodule
`default_nettype wire

/* rtl/csv_top.sv */
// Purpose: Read-only status variable bank with block-read port
// Assumes: Pins are asynchronous; ADC, supply and config from i_clk logic
// Notes:   Each block read streams from a snapshot taken at its start
//
// Notes on behaviour
// - Last full reset cause kept as code 0,1,2,4,8,16 or 32.
// - Software reset command never touches the reset cause.
// - Supply voltage reported unsigned 16-bit in millivolts.
// - Unsigned 32-bit millisecond uptime, restarted only by full reset.
// - Signed 32-bit tick count from the transmit and receive encoder pins.
// - Hobby pulse width in twelfths of a microsecond, all-ones if invalid.
// - Four analog levels, 0xFFFE near rail, 0xFFFF when unavailable.
// - Pin levels byte, bits 0 to 4 pins, bits 5 to 7 zero.
// - Pin drive byte, two bits each: clock, data, transmit, receive.
// - Drive code 0 high-Z, 1 pull-up, 2 low, 3 high.
// - Hobby pulse pin has no drive field.
// - Microstep setting reported as unsigned 8-bit code.
// - Microstep codes 0 to 9; code 6 half step full current.
// - Block read returns consecutive bytes from the given offset.
`timescale 1ns/1ps
`default_nettype none
module csv_top
  import csv_pkg::*;
#(
  parameter int P_CYC_PER_MS        = CYC_PER_MS,
  parameter int P_HOBBY_TIMEOUT_CYC = HOBBY_TIMEOUT_CYC
)(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [5:0]  i_rst_src,
  input  wire logic        i_pin_scl,
  input  wire logic        i_pin_sda,
  input  wire logic        i_pin_tx,
  input  wire logic        i_pin_rx,
  input  wire logic        i_pin_hobby,
  input  wire logic        i_supply_valid,
  input  wire logic [15:0] i_supply_mv,
  input  wire logic        i_adc_valid,
  input  wire logic [1:0]  i_adc_chan,
  input  wire logic [15:0] i_adc_data,
  input  wire logic [3:0]  i_analog_en,
  input  wire csv_drive_t  i_drive_scl,
  input  wire csv_drive_t  i_drive_sda,
  input  wire csv_drive_t  i_drive_tx,
  input  wire csv_drive_t  i_drive_rx,
  input  wire logic [7:0]  i_ustep,
  input  wire logic        i_blk_req,
  input  wire logic [7:0]  i_blk_offset,
  input  wire logic [7:0]  i_blk_len,
  output logic             o_blk_busy,
  output logic             o_blk_valid,
  output logic      [7:0]  o_blk_data,
  output logic             o_blk_last
);

  typedef enum logic [0:0] {
    BLK_IDLE,
    BLK_SEND
  } csv_blk_state_t;

  logic [LVL_PINS-1:0] pin_raw;
  logic [LVL_PINS-1:0] sync1_r;
  logic [LVL_PINS-1:0] sync2_r;
  logic [LVL_PINS-1:0] sync3_r;
  logic [LVL_PINS-1:0] pin_lvl_r;
  logic                cap_pend_r;
  logic [7:0]          cause_r;
  logic [15:0]         supply_r;
  logic [31:0]         cyc_r;
  logic [31:0]         uptime_r;
  logic [31:0]         quad_count;
  logic [15:0]         hobby_width;
  logic [15:0]         an_r [AN_CHANNELS];
  logic [7:0]          levels_r;
  logic [7:0]          drive_r;
  logic [7:0]          ustep_r;
  logic [8*BANK_BYTES-1:0] live;
  logic [7:0]          snap_r [BANK_BYTES];
  csv_blk_state_t      blk_state_r;
  logic [7:0]          idx_r;
  logic [7:0]          left_r;
  logic                busy_r;
  logic                valid_r;
  logic [7:0]          data_r;
  logic                last_r;
  logic                accept;
  logic [7:0]          rel_idx;
  logic [7:0]          sel_byte;
  logic [7:0]          sent_r;
  logic [7:0]          len_hold_r;

  assign pin_raw[LVL_BIT_SCL]   = i_pin_scl;
  assign pin_raw[LVL_BIT_SDA]   = i_pin_sda;
  assign pin_raw[LVL_BIT_TX]    = i_pin_tx;
  assign pin_raw[LVL_BIT_RX]    = i_pin_rx;
  assign pin_raw[LVL_BIT_HOBBY] = i_pin_hobby;

  assign o_blk_busy  = busy_r;
  assign o_blk_valid = valid_r;
  assign o_blk_data  = data_r;
  assign o_blk_last  = last_r;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  // Level accepted only when stages two and three agree
  generate
    for (genvar g = 0; g < LVL_PINS; g++) begin : g_sync
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          sync1_r[g]   <= 1'b0;
          sync2_r[g]   <= 1'b0;
          sync3_r[g]   <= 1'b0;
          pin_lvl_r[g] <= 1'b0;
        end else begin
          sync1_r[g] <= pin_raw[g];
          sync2_r[g] <= sync1_r[g];
          sync3_r[g] <= sync2_r[g];
          if (sync2_r[g] == sync3_r[g]) begin
            pin_lvl_r[g] <= sync3_r[g];
          end
        end
      end
    end
  endgenerate

  // ************************************************************
  // Reset cause
  // ************************************************************
  // cause caught after release
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cap_pend_r <= 1'b1;
      cause_r    <= CAUSE_POWER_UP;
    end else if (cap_pend_r) begin
      cap_pend_r <= 1'b0;
      if (i_rst_src[0]) begin
        cause_r <= CAUSE_BROWN;
      end else if (i_rst_src[1]) begin
        cause_r <= CAUSE_EXT_LINE;
      end else if (i_rst_src[2]) begin
        cause_r <= CAUSE_WDOG;
      end else if (i_rst_src[3]) begin
        cause_r <= CAUSE_SOFTWARE;
      end else if (i_rst_src[4]) begin
        cause_r <= CAUSE_STK_OVF;
      end else if (i_rst_src[5]) begin
        cause_r <= CAUSE_STK_UNF;
      end else begin
        cause_r <= CAUSE_POWER_UP;
      end
    end
  end

  AST_CAUSE_HOLD : assert property (
    @(posedge i_clk) disable iff (i_rst)
    !cap_pend_r |=> $stable(cause_r))
    else $error("reset cause changed outside a full reset");

  AST_CAUSE_CODE : assert property (
    @(posedge i_clk) disable iff (i_rst)
    !cap_pend_r |-> $countones(cause_r) <= 1 && cause_r[7:6] == 2'h0)
    else $error("reset cause holds an illegal code");

  // ************************************************************
  // Supply voltage and uptime
  // ************************************************************
  // millivolt sample
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      supply_r <= SUPPLY_RST;
    end else if (i_supply_valid) begin
      supply_r <= i_supply_mv;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cyc_r    <= COUNT32_RST;
      uptime_r <= COUNT32_RST;
    end else if (cyc_r == 32'(P_CYC_PER_MS - 1)) begin
      cyc_r    <= COUNT32_RST;
      uptime_r <= 32'(uptime_r + 32'h1);
    end else begin
      cyc_r <= 32'(cyc_r + 32'h1);
    end
  end

  AST_UPTIME_TICK : assert property (
    @(posedge i_clk) disable iff (i_rst)
    (cyc_r == 32'(P_CYC_PER_MS - 1)) |=>
      uptime_r == 32'($past(uptime_r) + 32'h1) ##1 $stable(uptime_r))
    else $error("uptime did not advance once per millisecond");

  // ************************************************************
  // Encoder and hobby pulse
  // ************************************************************
  // encoder shares serial pins
  csv_quad_dec u_quad (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_a     (pin_lvl_r[LVL_BIT_TX]),
    .i_b     (pin_lvl_r[LVL_BIT_RX]),
    .o_count (quad_count)
  );

  csv_pulse_meas #(
    .P_TIMEOUT_CYC (P_HOBBY_TIMEOUT_CYC)
  ) u_pulse (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_pulse (pin_lvl_r[LVL_BIT_HOBBY]),
    .o_width (hobby_width)
  );

  // ************************************************************
  // Analog levels
  // ************************************************************
  // disabled or unread shows all-ones
  generate
    for (genvar c = 0; c < AN_CHANNELS; c++) begin : g_an
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          an_r[c] <= NO_READING;
        end else if (!i_analog_en[c]) begin
          an_r[c] <= NO_READING;
        end else if (i_adc_valid && i_adc_chan == 2'(c)) begin
          // A real full-scale sample must not look like no reading
          an_r[c] <= (i_adc_data == NO_READING) ? ANALOG_MAX : i_adc_data;
        end
      end
    end
  endgenerate

  AST_AN_DISABLED : assert property (
    @(posedge i_clk) disable iff (i_rst)
    !i_analog_en[1] |=> an_r[1] == NO_READING)
    else $error("disabled analog channel not all-ones");

  AST_AN_SAMPLE : assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_adc_valid && i_analog_en[2] && i_adc_chan == 2'h2 |=>
      an_r[2] != NO_READING)
    else $error("valid analog sample reported as unavailable");

  // ************************************************************
  // Pin levels, drive states, microstep
  // ************************************************************
  // levels with reserved zeros
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      levels_r <= 8'h00;
    end else begin
      levels_r <= {3'h0, pin_lvl_r};
    end
  end

  AST_LEVELS_RSV : assert property (
    @(posedge i_clk) disable iff (i_rst)
    levels_r[7:5] == 3'h0)
    else $error("reserved pin level bits set");

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      drive_r <= 8'h00;
    end else begin
      drive_r[DRV_POS_SCL +: 2] <= i_drive_scl;
      drive_r[DRV_POS_SDA +: 2] <= i_drive_sda;
      drive_r[DRV_POS_TX +: 2]  <= i_drive_tx;
      drive_r[DRV_POS_RX +: 2]  <= i_drive_rx;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ustep_r <= USTEP_FULL;
    end else if (i_ustep <= USTEP_MAX) begin
      ustep_r <= i_ustep;
    end
  end

  AST_USTEP_RANGE : assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_ustep > USTEP_MAX |=> ustep_r == $past(ustep_r) && ustep_r <= USTEP_MAX)
    else $error("microstep setting took an unknown code");

  // ************************************************************
  // Block read
  // ************************************************************
  // little-endian byte image
  assign live = {ustep_r, drive_r, levels_r, an_r[3], an_r[2], an_r[1],
                 an_r[0], hobby_width, quad_count, uptime_r, supply_r,
                 cause_r};

  assign accept  = i_blk_req && !busy_r && (i_blk_len != 8'h00);
  assign rel_idx = 8'(idx_r - OFS_RESET_CAUSE);

  always_comb begin
    sel_byte = UNMAPPED_BYTE;
    if (idx_r >= OFS_RESET_CAUSE && idx_r <= OFS_USTEP) begin
      sel_byte = snap_r[rel_idx[4:0]];
    end
  end

  // Snapshot keeps multi-byte values coherent across a read
  generate
    for (genvar b = 0; b < BANK_BYTES; b++) begin : g_snap
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          snap_r[b] <= 8'h00;
        end else if (accept) begin
          snap_r[b] <= live[8*b +: 8];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      blk_state_r <= BLK_IDLE;
      idx_r       <= 8'h00;
      left_r      <= 8'h00;
      valid_r     <= 1'b0;
      data_r      <= 8'h00;
      last_r      <= 1'b0;
    end else begin
      case (blk_state_r)
        BLK_IDLE: begin
          valid_r <= 1'b0;
          last_r  <= 1'b0;
          if (accept) begin
            idx_r       <= i_blk_offset;
            left_r      <= i_blk_len;
            blk_state_r <= BLK_SEND;
          end
        end
        BLK_SEND: begin
          valid_r <= 1'b1;
          data_r  <= sel_byte;
          last_r  <= (left_r == 8'h01);
          idx_r   <= 8'(idx_r + 8'h1);
          left_r  <= 8'(left_r - 8'h1);
          if (left_r == 8'h01) begin
            blk_state_r <= BLK_IDLE;
          end
        end
        default: begin
          blk_state_r <= BLK_IDLE;
        end
      endcase
    end
  end

  // Busy covers the whole stream; requests meanwhile are dropped
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      busy_r <= 1'b0;
    end else if (accept) begin
      busy_r <= 1'b1;
    end else if (last_r) begin
      busy_r <= 1'b0;
    end
  end

  // Byte counter for checking stream length
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sent_r     <= 8'h00;
      len_hold_r <= 8'h00;
    end else if (accept) begin
      sent_r     <= 8'h00;
      len_hold_r <= i_blk_len;
    end else if (valid_r) begin
      sent_r <= 8'(sent_r + 8'h1);
    end
  end

  AST_BLK_START : assert property (
    @(posedge i_clk) disable iff (i_rst)
    accept |=> busy_r && !valid_r ##1 valid_r)
    else $error("block read did not start on time");

  AST_BLK_LEN : assert property (
    @(posedge i_clk) disable iff (i_rst)
    valid_r && last_r |-> 8'(sent_r + 8'h1) == len_hold_r ##1
      !valid_r && !busy_r)
    else $error("block read length wrong");

  AST_READ_NO_EFFECT : assert property (
    @(posedge i_clk) disable iff (i_rst)
    valid_r && !cap_pend_r |=> $stable(cause_r) && $stable(ustep_r) ||
      $past(i_ustep) <= USTEP_MAX)
    else $error("block read disturbed a variable");

endmodule
`default_nettype wire

/* dv/csv_host.sv */
// Purpose: Host model issuing block reads of the status bank
// Assumes: One read at a time, started while the bank is idle
// Notes:   Released offset and length show the inverse pattern
`timescale 1ns/1ps
`default_nettype none
module csv_host (
  input  wire logic       i_clk,
  input  wire logic       i_valid,
  input  wire logic [7:0] i_data,
  output logic            o_req,
  output logic      [7:0] o_offset,
  output logic      [7:0] o_len
);
  logic [7:0] got [0:255];
  initial begin
    o_req    = 1'b0;
    o_offset = 8'h00;
    o_len    = 8'h00;
  end
  // drive byte logged, never trusted for bus pins
  task automatic rd(input logic [7:0] off, input logic [7:0] n);
    int k;
    int w;
    k = 0;
    w = 0;
    for (int i = 0; i < 256; i++) got[i] = 8'hXX;
    @(posedge i_clk);
    #1 o_req = 1'b1;
    o_offset = off;
    o_len = n;
    @(posedge i_clk);
    #1 o_req = 1'b0;
    o_offset = ~off;
    o_len = ~n;
    while (k < int'(n) && w < 600) begin
      @(posedge i_clk);
      #1 w++;
      if (i_valid === 1'b1) begin
        got[k] = i_data;
        k++;
      end
    end
    @(posedge i_clk);
    #1;
  endtask
endmodule
`default_nettype wire

/* dv/testbench.sv */
// Purpose: Self-checking bench for the status variable bank
// Assumes: Short millisecond and pulse timeout counts
// Notes:   Bank read whole from its first offset
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import csv_pkg::*;
  localparam int MSC = 8;
  localparam int HOB_CYC = 30;
  localparam logic [31:0] HOB_W =
    32'(HOB_CYC * CLK_PERIOD_NS * HOBBY_UNITS_US / US_NS);
  logic clk = 1'b0, rst = 1'b1, sv = 1'b0, av = 1'b0;
  logic scl = 1'b1, sda = 1'b0, tx = 1'b0, rx = 1'b0, hob = 1'b0;
  logic [5:0] src = 6'h04;
  logic [1:0] ach = 2'h0;
  logic [15:0] smv = 16'h0000, adat = 16'h0000;
  logic [3:0] aen = 4'hD;
  logic [7:0] ust = 8'h06, off, len, dat;
  logic req, busy, vld, lst;
  logic [1:0] seq [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
  logic [31:0] u0, d;
  int fail_count = 0, n_tests = 0, cyc = 0, t0, e;
  int nlast = 0, nbusy = 0;
  always #20 clk = ~clk;
  always @(posedge clk) cyc++;
  // Stream flags counted as the host sees them
  always @(posedge clk) begin
    if (lst === 1'b1 && vld === 1'b1) nlast++;
    if (busy === 1'b1) nbusy++;
  end
  csv_top #(.P_CYC_PER_MS(MSC), .P_HOBBY_TIMEOUT_CYC(200)) csv_top_i (
    .i_clk(clk), .i_rst(rst), .i_rst_src(src), .i_pin_scl(scl),
    .i_pin_sda(sda), .i_pin_tx(tx), .i_pin_rx(rx), .i_pin_hobby(hob),
    .i_supply_valid(sv), .i_supply_mv(smv), .i_adc_valid(av),
    .i_adc_chan(ach), .i_adc_data(adat), .i_analog_en(aen),
    .i_drive_scl(DRV_HIGH_Z), .i_drive_sda(DRV_PULL_UP),
    .i_drive_tx(DRV_LOW), .i_drive_rx(DRV_HIGH), .i_ustep(ust),
    .i_blk_req(req), .i_blk_offset(off), .i_blk_len(len),
    .o_blk_busy(busy), .o_blk_valid(vld), .o_blk_data(dat),
    .o_blk_last(lst));
  csv_host csv_host_i (.i_clk(clk), .i_valid(vld), .i_data(dat),
    .o_req(req), .o_offset(off), .o_len(len));
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, x, s);
    end
  endtask
  // Bytes low first from a whole-bank read
  function automatic logic [31:0] bk(input logic [7:0] o, input int n);
    bk = 32'h0;
    for (int b = n - 1; b >= 0; b--)
      bk = {bk[23:0], csv_host_i.got[int'(o) - int'(OFS_RESET_CAUSE) + b]};
  endfunction
  task automatic adc(input logic [1:0] c, input logic [15:0] v);
    @(posedge clk);
    #1 av = 1'b1;
    ach = c;
    adat = v;
    @(posedge clk);
    #1 av = 1'b0;
  endtask
  task automatic bank;
    csv_host_i.rd(OFS_RESET_CAUSE, 8'(BANK_BYTES));
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    close_out();
  end
  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    @(posedge clk);
    #1 sv = 1'b1;
    smv = 16'h1234;
    @(posedge clk);
    #1 sv = 1'b0;
    adc(2'h0, 16'hABCD);
    adc(2'h1, 16'h1111);
    adc(2'h2, 16'hFFFF);
    adc(2'h3, 16'h0000);
    t0 = cyc;
    bank();
    chk("cause", bk(OFS_RESET_CAUSE, 1), 32'(CAUSE_WDOG));
    chk("supply", bk(OFS_SUPPLY_MV, 2), 32'h1234);
    chk("quad", bk(OFS_QUAD, 4), 32'h0);
    chk("hobby", bk(OFS_HOBBY, 2), 32'hFFFF);
    chk("an_scl", bk(OFS_AN_SCL, 2), 32'hABCD);
    chk("an_sda", bk(OFS_AN_SDA, 2), 32'(NO_READING));
    chk("an_tx", bk(OFS_AN_TX, 2), 32'(ANALOG_MAX));
    chk("an_rx", bk(OFS_AN_RX, 2), 32'h0);
    chk("levels", bk(OFS_LEVELS, 1), 32'h01);
    chk("drive", bk(OFS_DRIVE, 1), 32'hE4);
    chk("ustep", bk(OFS_USTEP, 1), 32'(USTEP_HALF_100));
    chk("busy", nbusy, 32'(BANK_BYTES + 1));
    chk("last", nlast, 32'h1);
    u0 = bk(OFS_UPTIME, 4);
    ust = 8'h0C;
    for (int i = 0; i < 4; i++) begin
      {tx, rx} = seq[i];
      repeat (6) @(posedge clk);
      #1;
    end
    hob = 1'b1;
    repeat (HOB_CYC) @(posedge clk);
    #1 hob = 1'b0;
    repeat (10) @(posedge clk);
    e = (cyc - t0) / MSC;
    bank();
    d = bk(OFS_UPTIME, 4) - u0;
    chk("uptime", 32'(d >= e - 1 && d <= e + 1), 32'h1);
    chk("quad_up", bk(OFS_QUAD, 4), 32'h4);
    chk("hobby_w", bk(OFS_HOBBY, 2), HOB_W);
    chk("ustep_hold", bk(OFS_USTEP, 1), 32'(USTEP_HALF_100));
    repeat (250) @(posedge clk);
    csv_host_i.rd(8'hFF, 8'h34);
    chk("wrap", 32'(csv_host_i.got[0]), 32'h0);
    chk("below", 32'(csv_host_i.got[8'h32]), 32'h0);
    chk("at_cause", 32'(csv_host_i.got[8'h33]), 32'(CAUSE_WDOG));
    bank();
    chk("hobby_lost", bk(OFS_HOBBY, 2), 32'hFFFF);
    src = 6'h03;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    repeat (6) @(posedge clk);
    bank();
    chk("cause2", bk(OFS_RESET_CAUSE, 1), 32'(CAUSE_BROWN));
    chk("uptime0", 32'(bk(OFS_UPTIME, 4) < 32'h4), 32'h1);
    chk("last_all", nlast, 32'h5);
    close_out();
  end
endmodule
`default_nettype wire
